// [acc_adc_model.sv]
// Behavioural converter core that answers the control block
`timescale 1ns/1ps
module acc_adc_model
  import acc_pkg::*;
#(
  parameter int LAT = 4
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            start,
  input  wire logic [CH_W-1:0] channel,
  input  wire logic            route_dac,
  input  wire logic            ext_ref,
  input  wire logic            slow,
  output logic                 done,
  output logic [RES_W-1:0]     data
);
  // ==========================================================
  // Conversion timing
  int               cnt;
  logic [RES_W-1:0] last;

  // Code encodes what was sampled; junk on the bus outside done
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      cnt = 0;
      last = 12'h0;
      data <= 12'h0;
    end else if (start) begin
      cnt = slow ? 3 * LAT : LAT;
      last = {route_dac, ext_ref, channel, 6'h15};
      data <= ~last;
    end else if (cnt == 1) begin
      cnt = 0;
      done <= 1'b1;
      data <= last;
    end else begin
      if (cnt > 0) cnt = cnt - 1;
      data <= ~last; // Stale value never looks valid
    end
  end
endmodule : acc_adc_model

// [acc_pkg.sv]
// Shared constants and types for the converter control block
package acc_pkg;

  // ==========================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] OFF_CTRL1  = 8'h00;
  localparam logic [7:0] OFF_CTRL2  = 8'h04;
  localparam logic [7:0] OFF_CAL    = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_OFFSET = 8'h18;
  localparam logic [7:0] OFF_GAIN   = 8'h1c;

  // ==========================================================
  // Field positions
  localparam int C1_HW_TRIG  = 0;
  localparam int C1_T2_TRIG  = 1;
  localparam int C1_SPI_CAP  = 2;
  localparam int C1_EXT_REF  = 6;
  localparam int C2_SINGLE   = 4;
  localparam int C2_CONT     = 5;
  localparam int CAL_SELF    = 0;
  localparam int CAL_SYS     = 1;
  localparam int CAL_BUSY    = 2;
  localparam int ST_DONE     = 0;
  localparam int ST_CAL      = 1;

  // ==========================================================
  // Widths and reset values
  localparam int RES_W = 12;
  localparam int CH_W  = 4;
  localparam int ST_W  = 2;
  localparam logic [7:0]      CTRL1_RST  = 8'h00;
  localparam logic [7:0]      CTRL2_RST  = 8'h00;
  localparam logic [ST_W-1:0] STAT_RST   = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST   = 2'h0;

  // ==========================================================
  // Channel codes: 0..5 external, then internal sources
  localparam logic [CH_W-1:0] CH_EXT4 = 4'h4;
  localparam logic [CH_W-1:0] CH_EXT5 = 4'h5;
  localparam logic [CH_W-1:0] CH_TEMP = 4'h8;
  localparam logic [CH_W-1:0] CH_DAC_OUTPUT_ZERO = 4'h9;
  localparam logic [CH_W-1:0] CH_DAC_OUTPUT_ONE = 4'ha;
  localparam logic [CH_W-1:0] CH_VREF = 4'hb;
  localparam logic [CH_W-1:0] CH_ANALOG_GROUND = 4'hc;

  // ==========================================================
  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_WAIT = 2'b10
  } acc_state_t;

endpackage : acc_pkg

// [acc_spi_capture.sv]
// Holding stage that hands finished results to the SPI transmitter
`timescale 1ns/1ps
module acc_spi_capture #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] data,
  input  wire logic         ready,
  output logic              valid,
  output logic [W-1:0]      dout
);

  logic         valid_r;
  logic         valid_nxt;
  logic [W-1:0] data_r;
  logic [W-1:0] data_nxt;

  // ==========================================================
  // A result arriving while one waits unsent is dropped:
  // the oldest word is never torn mid-handshake
  always_comb begin
    valid_nxt = valid_r;
    data_nxt  = data_r;
    if (valid_r && ready) begin
      valid_nxt = 1'b0;
    end
    if (load && (!valid_r || ready)) begin
      valid_nxt = 1'b1;
      data_nxt  = data;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
      data_r  <= '0;
    end else begin
      valid_r <= valid_nxt;
      data_r  <= data_nxt;
    end
  end

  assign valid = valid_r;
  assign dout  = data_r;

  a_spi_hold : assert property (@(posedge clk) disable iff (rst)
    valid && !ready |=> valid && $stable(dout))
    else $error("spi word changed before accepted");

endmodule : acc_spi_capture

// [acc_sync_edge.sv]
// Two-stage synchroniser with rising-edge pulse for a pin input
`timescale 1ns/1ps
module acc_sync_edge (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic last_r;
  logic rise_r;
  logic rise_nxt;

  // ==========================================================
  // Edge detect looks only at the second stage
  always_comb begin
    rise_nxt = sync_r & ~last_r;
  end

  // Registers; the first stage feeds the second only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;

  a_edge_single : assert property (@(posedge clk) disable iff (rst)
    rise |=> !rise) else $error("edge pulse longer than one cycle");

endmodule : acc_sync_edge

// [acc_top.sv]
// Converter control: triggers, channel, reference, calibration, APB
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  input  wire logic             CLK_SYS,
  input  wire logic             RST,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic [31:0]           PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic             CONVERT_START_PIN,
  input  wire logic             TIMER2_OVF,
  input  wire logic             DAC_OUTPUT_ZERO_EN,
  input  wire logic             DAC_OUTPUT_ONE_EN,
  input  wire logic [RES_W-1:0] FACTORY_OFFSET,
  input  wire logic [RES_W-1:0] FACTORY_GAIN,
  input  wire logic             ADC_DONE,
  input  wire logic [RES_W-1:0] ADC_DATA,
  output logic                  ADC_START,
  output logic [CH_W-1:0]       ADC_CHANNEL,
  output logic                  ADC_ROUTE_DAC,
  output logic                  ADC_EXT_REF,
  output logic                  COEF_LOAD,
  output logic [RES_W-1:0]      COEF_OFFSET,
  output logic [RES_W-1:0]      COEF_GAIN,
  input  wire logic             SPI_TX_READY,
  output logic                  SPI_TX_VALID,
  output logic [15:0]           SPI_TX_DATA,
  output logic                  IRQ
);

  // ==========================================================
  // Declarations
  acc_state_t       state_r,   state_nxt;
  logic [7:0]       ctrl1_r,   ctrl1_nxt;
  logic [7:0]       ctrl2_r,   ctrl2_nxt;
  logic [1:0]       cal_req_r, cal_req_nxt;
  logic [1:0]       cal_act_r, cal_act_nxt;
  logic             pend_r,    pend_nxt;
  logic [ST_W-1:0]  stat_r,    stat_nxt;
  logic [ST_W-1:0]  mask_r,    mask_nxt;
  logic [15:0]      result_r,  result_nxt;
  logic [RES_W-1:0] offs_r,    offs_nxt;
  logic [RES_W-1:0] gain_r,    gain_nxt;
  logic             start_r,   start_nxt;
  logic [CH_W-1:0]  chan_r,    chan_nxt;
  logic             route_r,   route_nxt;
  logic             cload_r,   cload_nxt;
  logic             spi_ld_r,  spi_ld_nxt;
  logic             irq_r,     irq_nxt;
  logic             pready_r,  pready_nxt;
  logic             perr_r,    perr_nxt;
  logic [31:0]      prdata_r,  prdata_nxt;
  logic             pin_rise;
  logic             wr_fire;
  logic             wr_c1;
  logic             wr_c2;
  logic             wr_cal;
  logic             hw_trig;
  logic             t2_trig;
  logic             conv_done;

  // ==========================================================
  // Pin trigger synchroniser
  acc_sync_edge u_pin (
    .clk      (CLK_SYS),
    .rst      (RST),
    .async_in (CONVERT_START_PIN),
    .rise     (pin_rise)
  );

  // Result forwarding stage toward SPI
  acc_spi_capture #(.W(16)) u_spi (
    .clk   (CLK_SYS),
    .rst   (RST),
    .load  (spi_ld_r),
    .data  (result_r),
    .ready (SPI_TX_READY),
    .valid (SPI_TX_VALID),
    .dout  (SPI_TX_DATA)
  );

  // ==========================================================
  // Write strobes; writes land at the completing access edge
  assign wr_fire = PSEL & PENABLE & pready_r & PWRITE;
  assign wr_c1   = wr_fire & (PADDR == OFF_CTRL1);
  assign wr_c2   = wr_fire & (PADDR == OFF_CTRL2);
  assign wr_cal  = wr_fire & (PADDR == OFF_CAL);
  assign hw_trig = pin_rise & ctrl1_r[C1_HW_TRIG];
  assign t2_trig = TIMER2_OVF & ctrl1_r[C1_T2_TRIG];
  assign conv_done = (state_r == S_WAIT) & ADC_DONE;

  // ==========================================================
  // APB slave: one wait state, registered read data
  always_comb begin
    pready_nxt = PSEL & PENABLE & ~pready_r;
    perr_nxt   = 1'b0;
    prdata_nxt = prdata_r;
    if (PSEL && PENABLE && !pready_r) begin
      prdata_nxt = 32'h0;
      unique case (PADDR)
        OFF_CTRL1:  prdata_nxt[7:0] = ctrl1_r;
        OFF_CTRL2:  prdata_nxt[7:0] = ctrl2_r;
        OFF_CAL:    prdata_nxt[2:0] = {state_r != S_IDLE, cal_req_r};
        OFF_RESULT: prdata_nxt[15:0] = result_r;
        OFF_STATUS: prdata_nxt[ST_W-1:0] = stat_r;
        OFF_MASK:   prdata_nxt[ST_W-1:0] = mask_r;
        OFF_OFFSET: prdata_nxt[RES_W-1:0] = offs_r;
        OFF_GAIN:   prdata_nxt[RES_W-1:0] = gain_r;
        default:    perr_nxt = 1'b1; // Unmapped answers with error
      endcase
    end
  end

  // ==========================================================
  // Control, trigger and sequencer next state
  always_comb begin
    state_nxt   = state_r;
    ctrl1_nxt   = ctrl1_r;
    ctrl2_nxt   = ctrl2_r;
    cal_req_nxt = cal_req_r;
    cal_act_nxt = cal_act_r;
    pend_nxt    = pend_r;
    mask_nxt    = mask_r;
    result_nxt  = result_r;
    offs_nxt    = offs_r;
    gain_nxt    = gain_r;
    start_nxt   = 1'b0;
    chan_nxt    = chan_r;
    route_nxt   = route_r;
    cload_nxt   = 1'b0;
    spi_ld_nxt  = 1'b0;
    // Sticky events: a set in the clearing cycle survives
    stat_nxt = stat_r;
    if (wr_fire && PADDR == OFF_STATUS) begin
      stat_nxt = stat_r & ~PWDATA[ST_W-1:0];
    end
    if (wr_c1) begin
      ctrl1_nxt = PWDATA[7:0];
    end
    if (wr_c2) begin
      ctrl2_nxt = PWDATA[7:0] & ~(8'h01 << C2_SINGLE);
    end
    if (wr_fire && PADDR == OFF_MASK) begin
      mask_nxt = PWDATA[ST_W-1:0];
    end
    if ((wr_c2 && PWDATA[C2_SINGLE]) || hw_trig || t2_trig) begin
      pend_nxt = 1'b1;
    end
    unique case (state_r)
      S_LOAD: begin
        offs_nxt  = FACTORY_OFFSET;
        gain_nxt  = FACTORY_GAIN;
        cload_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      S_IDLE: begin
        if (cal_req_r != 2'b00) begin
          // Self calibration measures ground; system uses field
          cal_act_nxt = cal_req_r[CAL_SELF] ? 2'b01 : 2'b10;
          cal_req_nxt[cal_req_r[CAL_SELF] ? CAL_SELF : CAL_SYS] = 1'b0;
          chan_nxt  = cal_req_r[CAL_SELF] ? CH_ANALOG_GROUND : ctrl2_r[3:0];
          start_nxt = 1'b1;
          state_nxt = S_WAIT;
        end else if (pend_r || ctrl2_r[C2_CONT]) begin
          cal_act_nxt = 2'b00;
          pend_nxt  = 1'b0;
          chan_nxt  = ctrl2_r[3:0];
          start_nxt = 1'b1;
          state_nxt = S_WAIT;
        end
        // Shared pins carry the DAC while its output is on
        route_nxt = (chan_nxt == CH_EXT4 && DAC_OUTPUT_ZERO_EN) ||
                    (chan_nxt == CH_EXT5 && DAC_OUTPUT_ONE_EN);
      end
      S_WAIT: begin
        if (ADC_DONE) begin
          state_nxt = S_IDLE;
          if (cal_act_r[CAL_SELF]) begin
            offs_nxt  = ADC_DATA;
            cload_nxt = 1'b1;
          end else if (cal_act_r[CAL_SYS]) begin
            gain_nxt  = ADC_DATA;
            cload_nxt = 1'b1;
          end else begin
            result_nxt = {chan_r, ADC_DATA};
            spi_ld_nxt = ctrl1_r[C1_SPI_CAP];
          end
          stat_nxt[cal_act_r != 2'b00 ? ST_CAL : ST_DONE] = 1'b1;
        end
      end
      default: state_nxt = S_LOAD;
    endcase
    // After the case so a request in the taking cycle is not lost
    if (wr_cal) begin
      cal_req_nxt = cal_req_nxt | PWDATA[1:0];
    end
    irq_nxt = |(stat_r & mask_r);
  end

  // ==========================================================
  // Registers; reset schedules the coefficient load
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_r   <= S_LOAD;
      ctrl1_r   <= CTRL1_RST;
      ctrl2_r   <= CTRL2_RST;
      cal_req_r <= 2'b00;
      cal_act_r <= 2'b00;
      pend_r    <= 1'b0;
      stat_r    <= STAT_RST;
      mask_r    <= MASK_RST;
      result_r  <= 16'h0;
      offs_r    <= '0;
      gain_r    <= '0;
      start_r   <= 1'b0;
      chan_r    <= 4'h0;
      route_r   <= 1'b0;
      cload_r   <= 1'b0;
      spi_ld_r  <= 1'b0;
      irq_r     <= 1'b0;
      pready_r  <= 1'b0;
      perr_r    <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      state_r   <= state_nxt;
      ctrl1_r   <= ctrl1_nxt;
      ctrl2_r   <= ctrl2_nxt;
      cal_req_r <= cal_req_nxt;
      cal_act_r <= cal_act_nxt;
      pend_r    <= pend_nxt;
      stat_r    <= stat_nxt;
      mask_r    <= mask_nxt;
      result_r  <= result_nxt;
      offs_r    <= offs_nxt;
      gain_r    <= gain_nxt;
      start_r   <= start_nxt;
      chan_r    <= chan_nxt;
      route_r   <= route_nxt;
      cload_r   <= cload_nxt;
      spi_ld_r  <= spi_ld_nxt;
      irq_r     <= irq_nxt;
      pready_r  <= pready_nxt;
      perr_r    <= perr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign PRDATA        = prdata_r;
  assign PREADY        = pready_r;
  assign PSLVERR       = perr_r;
  assign ADC_START     = start_r;
  assign ADC_CHANNEL   = chan_r;
  assign ADC_ROUTE_DAC = route_r;
  assign ADC_EXT_REF   = ctrl1_r[C1_EXT_REF];
  assign COEF_LOAD     = cload_r;
  assign COEF_OFFSET   = offs_r;
  assign COEF_GAIN     = gain_r;
  assign IRQ           = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_factory_load : assert property ($fell(RST) |-> ##1 (COEF_LOAD &&
    COEF_OFFSET == $past(FACTORY_OFFSET)))
    else $error("factory coefficients not loaded after reset");
  a_ext_ref_sel : assert property (wr_c1 |=>
    ADC_EXT_REF == $past(PWDATA[C1_EXT_REF]))
    else $error("reference select did not follow write");
  a_result_word : assert property (conv_done && cal_act_r == 2'b00 |=>
    result_r == {$past(chan_r), $past(ADC_DATA)})
    else $error("result word format wrong");
  a_done_flag : assert property (conv_done && cal_act_r == 2'b00 |=>
    stat_r[ST_DONE])
    else $error("done flag not set");
  a_single_start : assert property (wr_c2 && PWDATA[C2_SINGLE] &&
    state_r == S_IDLE && cal_req_r == 2'b00 |-> ##[1:2] ADC_START)
    else $error("single conversion did not start");
  a_pin_start : assert property (hw_trig && state_r == S_IDLE &&
    cal_req_r == 2'b00 |-> ##[1:2] ADC_START)
    else $error("pin trigger did not start conversion");
  a_timer_start : assert property (t2_trig && state_r == S_IDLE &&
    cal_req_r == 2'b00 |-> ##[1:2] ADC_START)
    else $error("timer trigger did not start conversion");
  a_spi_forward : assert property (conv_done && cal_act_r == 2'b00 &&
    ctrl1_r[C1_SPI_CAP] && !SPI_TX_VALID |-> ##2 (SPI_TX_VALID &&
    SPI_TX_DATA == {$past(chan_r, 2), $past(ADC_DATA, 2)}))
    else $error("result not forwarded to spi");
  a_dac_route : assert property (ADC_START |-> ADC_ROUTE_DAC ==
    ((ADC_CHANNEL == CH_EXT4 && $past(DAC_OUTPUT_ZERO_EN)) ||
     (ADC_CHANNEL == CH_EXT5 && $past(DAC_OUTPUT_ONE_EN))))
    else $error("dac routing wrong for shared channel");
  a_self_cal_gnd : assert property (ADC_START && cal_act_r[CAL_SELF] |->
    ADC_CHANNEL == CH_ANALOG_GROUND)
    else $error("self calibration not on ground channel");
  a_cal_replace : assert property (conv_done && cal_act_r[CAL_SELF] |=>
    COEF_LOAD && COEF_OFFSET == $past(ADC_DATA))
    else $error("calibration did not replace offset");

  c_single : cover property (wr_c2 && PWDATA[C2_SINGLE] ##[1:4] ADC_START);
  c_cal    : cover property (conv_done && cal_act_r[CAL_SYS]);
  c_spi    : cover property (spi_ld_r ##1 SPI_TX_VALID);
  c_irq    : cover property (conv_done ##[1:3] IRQ);

endmodule : acc_top

// [acc_top_tb_top.sv]
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module acc_top_tb_top import acc_pkg::*;;
  // ==========================================================
  // Signals
  localparam logic [11:0] F_OFF  = 12'h3a5;
  localparam logic [11:0] F_GAIN = 12'h5c7;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        conv_pin, t2_ovf, dac_output_zero_en, dac_output_one_en, adc_done, adc_start;
  logic [11:0] adc_data, coef_off, coef_gain;
  logic [3:0]  adc_ch;
  logic        route, ext_ref, coef_load, spi_ready, spi_valid;
  logic [15:0] spi_data;
  logic        irq, slow, ref_on, mask_on;
  int          n_fail, tests_run, n_start;
  logic [3:0]  chans [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                              4'h8, 4'h9, 4'ha, 4'hb, 4'hc};

  acc_top i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CONVERT_START_PIN(conv_pin),
    .TIMER2_OVF(t2_ovf), .DAC_OUTPUT_ZERO_EN(dac_output_zero_en), .DAC_OUTPUT_ONE_EN(dac_output_one_en),
    .FACTORY_OFFSET(F_OFF), .FACTORY_GAIN(F_GAIN),
    .ADC_DONE(adc_done), .ADC_DATA(adc_data), .ADC_START(adc_start),
    .ADC_CHANNEL(adc_ch), .ADC_ROUTE_DAC(route), .ADC_EXT_REF(ext_ref),
    .COEF_LOAD(coef_load), .COEF_OFFSET(coef_off),
    .COEF_GAIN(coef_gain), .SPI_TX_READY(spi_ready),
    .SPI_TX_VALID(spi_valid), .SPI_TX_DATA(spi_data), .IRQ(irq));

  acc_adc_model #(.LAT(4)) i_adc (
    .clk(clk_sys), .rst(rst), .start(adc_start), .channel(adc_ch),
    .route_dac(route), .ext_ref(ext_ref), .slow(slow),
    .done(adc_done), .data(adc_data));

  // ==========================================================
  // Clock, start counter and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (adc_start === 1'b1) n_start++;
  end
  // Whole run is around a thousand cycles; this is ample margin
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end

  // ==========================================================
  // Helpers
  function automatic logic [11:0] expd(input logic [3:0] ch,
                                       input logic rt, input logic rf);
    return {rt, rf, ch, 6'h15};
  endfunction : expd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // APB transfer; request held until pready is seen high, for at most 20 extra cycles
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string msg);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp, msg);
  endtask : rd_chk

  task automatic wait_st(input int idx);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    r = '0;
    while (r[idx] !== 1'b1 && n < 40) begin
      xfer(1'b0, OFF_STATUS, 32'h0, r, e);
      n++;
    end
    chk(r[idx], 1'b1, "status bit never set");
  endtask : wait_st

  // Single start, then result, sticky flag and interrupt
  task automatic conv(input logic [3:0] ch, input logic rt);
    wr(OFF_CTRL2, {27'h0, 1'b1, ch});
    wait_st(ST_DONE);
    rd_chk(OFF_RESULT, {16'h0, ch, expd(ch, rt, ref_on)}, "result");
    rd_chk(OFF_STATUS, 32'h1, "done flag");
    tick(2);
    chk(irq, mask_on, "irq level");
    wr(OFF_STATUS, 32'h1);
    tick(2);
    chk(irq, 1'b0, "irq after clear");
  endtask : conv

  task automatic pulse_t2;
    @(posedge clk_sys);
    t2_ovf <= 1'b1;
    @(posedge clk_sys);
    t2_ovf <= 1'b0;
  endtask : pulse_t2

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    {psel, penable, pwrite, conv_pin, t2_ovf, dac_output_zero_en} = '0;
    {dac_output_one_en, spi_ready, slow, ref_on, mask_on} = '0;
    {paddr, pwdata, n_fail, tests_run, n_start} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    tick(1);
    chk(coef_load, 1'b1, "coef load pulse");
    chk(coef_off, F_OFF, "factory offset");
    chk(coef_gain, F_GAIN, "factory gain");
    rd_chk(OFF_GAIN, F_GAIN, "gain reg");
    rd_chk(OFF_CTRL1, CTRL1_RST, "ctrl1 reset");
    rd_chk(OFF_STATUS, STAT_RST, "status reset");
    xfer(1'b0, 8'h40, 32'h0, r, e);
    chk(e, 1'b1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    // External reference across every channel code
    wr(OFF_CTRL1, 32'h40);
    ref_on = 1'b1;
    tick(2);
    chk(ext_ref, 1'b1, "ext ref on");
    foreach (chans[i]) conv(chans[i], 1'b0);
    wr(OFF_CTRL1, 32'h0);
    ref_on = 1'b0;
    tick(2);
    chk(ext_ref, 1'b0, "ext ref off");
    // DAC sharing applies to channels four and five only
    @(posedge clk_sys);
    dac_output_zero_en <= 1'b1;
    conv(CH_EXT4, 1'b1);
    conv(CH_EXT5, 1'b0);
    @(posedge clk_sys);
    dac_output_one_en <= 1'b1;
    conv(CH_EXT5, 1'b1);
    conv(CH_DAC_OUTPUT_ZERO, 1'b0);
    @(posedge clk_sys);
    {dac_output_zero_en, dac_output_one_en} <= 2'b00;
    // Timer trigger, prompt then slow converter
    wr(OFF_CTRL1, 32'h2);
    wr(OFF_CTRL2, 32'h2);
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      pulse_t2();
      wait_st(ST_DONE);
      rd_chk(OFF_RESULT, {20'h2, expd(4'h2, 1'b0, 1'b0)}, "timer");
      wr(OFF_STATUS, 32'h1);
    end
    slow = 1'b0;
    // Pin trigger; timer pulse ignored while its enable is off
    wr(OFF_CTRL1, 32'h1);
    wr(OFF_CTRL2, 32'h3);
    @(posedge clk_sys);
    conv_pin <= 1'b1;
    wait_st(ST_DONE);
    rd_chk(OFF_RESULT, {20'h3, expd(4'h3, 1'b0, 1'b0)}, "pin");
    wr(OFF_STATUS, 32'h1);
    conv_pin <= 1'b0;
    pulse_t2();
    tick(20);
    rd_chk(OFF_STATUS, 32'h0, "timer masked");
    // Interrupt enabled, SPI capture with a stalled receiver
    wr(OFF_MASK, 32'h1);
    mask_on = 1'b1;
    wr(OFF_CTRL1, 32'h4);
    conv(4'h2, 1'b0);
    chk(spi_valid, 1'b1, "spi valid");
    chk(spi_data, {4'h2, expd(4'h2, 1'b0, 1'b0)}, "spi data");
    tick(3);
    chk(spi_valid, 1'b1, "spi held");
    @(posedge clk_sys);
    spi_ready <= 1'b1;
    tick(1);
    chk(spi_valid, 1'b0, "spi taken");
    spi_ready <= 1'b0;
    // Continuous mode restarts without software
    wr(OFF_CTRL1, 32'h0);
    n_start = 0;
    wr(OFF_CTRL2, 32'h21);
    tick(60);
    wr(OFF_CTRL2, 32'h0);
    chk(n_start >= 5, 1'b1, "continuous starts");
    tick(20);
    wr(OFF_STATUS, 32'h3);
    // Self then system calibration replace the coefficients
    wr(OFF_CAL, 32'h1);
    wait_st(ST_CAL);
    rd_chk(OFF_OFFSET, expd(CH_ANALOG_GROUND, 1'b0, 1'b0), "self cal");
    chk(coef_off, expd(CH_ANALOG_GROUND, 1'b0, 1'b0), "coef offset");
    wr(OFF_STATUS, 32'h3);
    wr(OFF_CTRL2, 32'h3);
    wr(OFF_CAL, 32'h2);
    wait_st(ST_CAL);
    rd_chk(OFF_GAIN, expd(4'h3, 1'b0, 1'b0), "system cal");
    chk(coef_gain, expd(4'h3, 1'b0, 1'b0), "coef gain");
    // Second reset brings the factory values back
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    tick(2);
    chk(coef_off, F_OFF, "offset reload");
    chk(irq, 1'b0, "irq after reset");
    conclude();
  end
endmodule : acc_top_tb_top
